// *** hw/sba_top.sv ***
`timescale 1ns/1ps
// Purpose: Secondary bus arbiter, secondary clock outputs, secondary reset
// Assumes: All inputs synchronous to mclk; rst is the primary reset
// Notes:   Data path and target signalling are outside this block
// Function
// - Four external requests plus bridge request arbitrate
// - Each external request set into high or low group; bridge always high
// - At most one grant; start only when idle
// - Two-level rotating priority, rotation per group
// - Strap low enables arbiter, high disables it
// - External mode: grant 0 is bridge request
// - External mode: request 0 is bridge grant
// - External mode: park when granted, idle, nothing pending
// - Primary side timed by rising clock edges
// - Secondary side timed by rising clock edges
// - Five secondary clocks at primary frequency
// - Each secondary clock individually disableable
// - Strap high plus deep sleep stops clocks low
// - Strap low leaves clocks running in sleep
// - Primary reset async, clears all, tristates outputs
// - Secondary reset from primary reset or bits
// - In secondary reset, controls float, data zero
// - Secondary reset holds until both causes clear
// - Secondary reset alone keeps register state
module sba_top (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       cfn_strap,
   input  wire logic       pwr_strap,
   input  wire logic       d3hot,
   input  wire logic [3:0] req_n,
   input  wire logic       bridge_req,
   input  wire logic       bus_idle,
   input  wire logic [3:0] hi_grp,
   input  wire logic [4:0] clk_dis,
   input  wire logic       sec_rst_bit,
   input  wire logic       chip_rst_bit,
   output logic [3:0]      gnt_n_o,
   output logic [3:0]      gnt_n_oe,
   output logic            bridge_gnt,
   output logic            bridge_park,
   output logic [4:0]      sclk_o,
   output logic            srst_n,
   output logic            sctl_oe,
   output logic            sdata_zero,
   output logic            p_oe_n
);
   sba_arb_if  arb ();
   sba_pkg::sba_state_e state_reg;
   sba_pkg::sba_state_e state_next;
   logic       ext_mode;
   logic [4:0] clk_off;
   logic [4:0] win_hold_reg;
   logic       sreset;

   // -----------------------------------------------------------------
   // Arbitration
   // -----------------------------------------------------------------

   // strap high selects the external arbiter
   assign ext_mode = cfn_strap;

   // bridge joins as requester index 4
   always_comb begin
      arb.req    = {bridge_req, ~req_n};
      arb.hi_grp = hi_grp;
   end

   sba_rot u_rot (
      .mclk (mclk),
      .rst  (rst),
      .arb  (arb)
   );

   // new owner chosen only while bus idle
   always_comb begin
      state_next = state_reg;
      arb.take   = 1'b0;
      case (state_reg)
         sba_pkg::SBA_IDLE: begin
            if (ext_mode)
               state_next = sba_pkg::SBA_EXT;
            else if (arb.any && bus_idle) begin
               state_next = sba_pkg::SBA_GRANT;
               arb.take   = 1'b1;
            end
         end
         sba_pkg::SBA_GRANT: state_next = bus_idle ? sba_pkg::SBA_GRANT
                                                   : sba_pkg::SBA_BUSY;
         sba_pkg::SBA_BUSY:  if (bus_idle) state_next = sba_pkg::SBA_IDLE;
         sba_pkg::SBA_EXT:   if (!ext_mode) state_next = sba_pkg::SBA_IDLE;
         default:            state_next = sba_pkg::SBA_IDLE;
      endcase
      // Grant holder that dropped its request before starting releases
      if (state_reg == sba_pkg::SBA_GRANT && bus_idle &&
          (arb.req & win_hold_reg) == 5'h00)
         state_next = sba_pkg::SBA_IDLE;
   end

   // Latch the winner for the whole tenure
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_reg    <= sba_pkg::SBA_IDLE;
         win_hold_reg <= 5'h00;
      end else begin
         state_reg <= state_next;
         if (arb.take)
            win_hold_reg <= arb.win;
         else if (state_next == sba_pkg::SBA_IDLE ||
                  state_next == sba_pkg::SBA_EXT)
            win_hold_reg <= 5'h00;
      end
   end

   // one-hot grant; grant 0 becomes bridge request
   // grants change only on the clock edge
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         gnt_n_o     <= sba_pkg::REQ_IDLE;
         bridge_gnt  <= 1'b0;
         bridge_park <= 1'b0;
      end else if (ext_mode) begin
         gnt_n_o     <= {3'h7, ~bridge_req};
         // request 0 is the bridge grant input
         bridge_gnt  <= ~req_n[0] & bus_idle;
         // park when granted, idle, nothing pending
         bridge_park <= ~req_n[0] & bus_idle & ~bridge_req;
      end else begin
         gnt_n_o     <= ~win_hold_reg[3:0];
         bridge_gnt  <= win_hold_reg[4];
         bridge_park <= 1'b0;
      end
   end

   // grant pins float during secondary reset
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         gnt_n_oe <= sba_pkg::REQ_IDLE;
      else if (sreset)
         gnt_n_oe <= sba_pkg::REQ_IDLE;
      else if (ext_mode)
         gnt_n_oe <= 4'hE;          // Only the request-out pin driven
      else
         gnt_n_oe <= 4'h0;
   end

   // -----------------------------------------------------------------
   // Secondary clocks
   // -----------------------------------------------------------------

   // strap and deep sleep stop all clocks
   // strap low leaves clocks alone in sleep
   assign clk_off = clk_dis | ((pwr_strap && d3hot) ? 5'h1F
                                                   : sba_pkg::CLK_ALL_OFF);

   sba_clkgen u_clk (
      .mclk  (mclk),
      .rst   (rst),
      .off   (clk_off),
      .clk_o (sclk_o)
   );

   // -----------------------------------------------------------------
   // Reset
   // -----------------------------------------------------------------

   // bits are inputs, no state cleared here
   assign sreset = sec_rst_bit | chip_rst_bit;

   // primary reset async; held till both clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         srst_n     <= 1'b0;
         sctl_oe    <= 1'b1;
         sdata_zero <= 1'b1;
         p_oe_n     <= 1'b1;
      end else begin
         srst_n     <= ~sreset;
         // controls float, data lines forced zero
         sctl_oe    <= sreset;
         sdata_zero <= sreset;
         p_oe_n     <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------

   // primary side registered on rising mclk
   // never more than one grant low
   a_one_grant: assert property (@(posedge mclk) disable iff (rst)
      $onehot0(~gnt_n_o) || cfn_strap)
      else $error("more than one grant asserted");

   // secondary reset follows bits after a cycle
   a_srst_hold: assert property (@(posedge mclk) disable iff (rst)
      (sec_rst_bit || chip_rst_bit) |=> !srst_n)
      else $error("secondary reset released early");

   // clocks low one cycle after sleep entry
   a_clk_stop: assert property (@(posedge mclk) disable iff (rst)
      (pwr_strap && d3hot) [*2] |-> sclk_o == 5'h00)
      else $error("secondary clocks not stopped");

   // external grant seen one cycle later
   a_ext_gnt: assert property (@(posedge mclk) disable iff (rst)
      (cfn_strap && !req_n[0] && bus_idle) |=> bridge_gnt)
      else $error("external grant not taken");

   a_ext_req: assert property (@(posedge mclk) disable iff (rst)
      cfn_strap |=> gnt_n_o[0] == !$past(bridge_req))
      else $error("request out wrong");

   a_park: assert property (@(posedge mclk) disable iff (rst)
      bridge_park |-> $past(!bridge_req && !req_n[0]))
      else $error("parked with pending transaction");

   a_sdata: assert property (@(posedge mclk) disable iff (rst)
      !srst_n |-> sdata_zero && sctl_oe)
      else $error("secondary lines not safe in reset");

   a_clk_dis: assert property (@(posedge mclk) disable iff (rst)
      clk_dis[0] [*2] |-> !sclk_o[0])
      else $error("disabled clock toggling");

   // grant pins mirror the latched owner
   a_gnt_hold: assert property (@(posedge mclk) disable iff (rst)
      !cfn_strap |=> gnt_n_o == ~$past(win_hold_reg[3:0]))
      else $error("grant pins differ from owner");

   // bridge grant mirrors the latched owner
   a_bgnt_hold: assert property (@(posedge mclk) disable iff (rst)
      !cfn_strap |=> bridge_gnt == $past(win_hold_reg[4]))
      else $error("bridge grant differs from owner");

   // a new owner only on an idle bus
   a_take_idle: assert property (@(posedge mclk) disable iff (rst)
      arb.take |-> bus_idle && state_reg == sba_pkg::SBA_IDLE)
      else $error("owner chosen on busy bus");

   a_take_onehot: assert property (@(posedge mclk) disable iff (rst)
      arb.take |-> $onehot(arb.win))
      else $error("winner not one-hot");

   a_win_req: assert property (@(posedge mclk) disable iff (rst)
      arb.take |-> (arb.win & ~arb.req) == 5'h00)
      else $error("winner did not request");

   // a high-group request beats the low group
   a_hi_first: assert property (@(posedge mclk) disable iff (rst)
      arb.take && (arb.req & {1'b1, hi_grp}) != 5'h00 |->
         (arb.win & {1'b1, hi_grp}) != 5'h00)
      else $error("low group won over high group");

   // no internal decision under an outside arbiter
   a_no_take_ext: assert property (@(posedge mclk) disable iff (rst)
      ext_mode |-> !arb.take)
      else $error("internal decision in external mode");

   // grants 3 to 1 stay off in external mode
   a_ext_gnt_off: assert property (@(posedge mclk) disable iff (rst)
      cfn_strap |=> gnt_n_o[3:1] == 3'h7)
      else $error("grant asserted in external mode");

   // only the request-out pin driven in external mode
   a_ext_oe: assert property (@(posedge mclk) disable iff (rst)
      cfn_strap && !sreset |=> gnt_n_oe == 4'hE)
      else $error("wrong pins driven in external mode");

   // every grant pin driven by the internal arbiter
   a_int_oe: assert property (@(posedge mclk) disable iff (rst)
      !cfn_strap && !sreset |=> gnt_n_oe == 4'h0)
      else $error("grant pins not driven");

   // grant pins float in secondary reset
   a_srst_oe: assert property (@(posedge mclk) disable iff (rst)
      sreset |=> gnt_n_oe == sba_pkg::REQ_IDLE)
      else $error("grant pins driven in reset");

   // controls float and data zero in reset
   a_srst_lines: assert property (@(posedge mclk) disable iff (rst)
      sreset |=> sctl_oe && sdata_zero)
      else $error("secondary lines active in reset");

   // secondary reset ends once both bits clear
   a_srst_rel: assert property (@(posedge mclk) disable iff (rst)
      !sec_rst_bit && !chip_rst_bit |=> srst_n)
      else $error("secondary reset stuck");

   // primary outputs driven once out of reset
   a_prim_drive: assert property (@(posedge mclk) disable iff (rst)
      1'b1 |=> !p_oe_n)
      else $error("primary outputs still floating");

   // parking only under an outside arbiter
   a_park_ext: assert property (@(posedge mclk) disable iff (rst)
      !cfn_strap |=> !bridge_park)
      else $error("parked with internal arbiter");

   // a parked bridge also holds the bus grant
   a_park_gnt: assert property (@(posedge mclk) disable iff (rst)
      bridge_park |-> bridge_gnt)
      else $error("parked without grant");

   // idle bus, grant and no work lead to parking
   a_park_set: assert property (@(posedge mclk) disable iff (rst)
      cfn_strap && !req_n[0] && bus_idle && !bridge_req |=> bridge_park)
      else $error("bridge did not park");

   // ungated outputs all share one phase
   a_clk_same: assert property (@(posedge mclk) disable iff (rst)
      (clk_dis == 5'h00 && !(pwr_strap && d3hot)) [*2] |->
         sclk_o == 5'h00 || sclk_o == 5'h1F)
      else $error("secondary clocks out of step");

   // the owner is kept for the whole tenure
   a_busy_owner: assert property (@(posedge mclk) disable iff (rst)
      state_reg == sba_pkg::SBA_BUSY |-> $stable(win_hold_reg))
      else $error("owner changed during tenure");

   // grants released after the bus returns idle
   a_gnt_release: assert property (@(posedge mclk) disable iff (rst)
      (state_reg == sba_pkg::SBA_BUSY && bus_idle) ##1 !cfn_strap |=>
         gnt_n_o == sba_pkg::REQ_IDLE)
      else $error("grant not released");

   // secondary reset leaves arbiter state alone
   a_srst_keep: assert property (@(posedge mclk) disable iff (rst)
      sreset && state_reg == sba_pkg::SBA_BUSY && !bus_idle |=>
         state_reg == sba_pkg::SBA_BUSY)
      else $error("arbiter state lost in reset");
endmodule // sba_top

// *** pkg/sba_pkg.sv ***
// Purpose: Shared constants and types for the secondary bus arbiter block
// Assumes: One clock (mclk, 250 MHz); arbiter inputs synchronous to it
// Notes:   Numbers used by more than one file live here
package sba_pkg;
   localparam int          NREQ        = 4;   // External request inputs
   localparam int          NCLK        = 5;   // Secondary clock outputs
   localparam int          CLK_HALF    = 4;   // mclk cycles per half period
   localparam logic [2:0]  DIV_W0      = 3'h0;
   localparam logic [3:0]  REQ_IDLE    = 4'hF; // All lines deasserted
   localparam logic [4:0]  CLK_ALL_OFF = 5'h00;
   // Arbiter state
   typedef enum logic [1:0] {
      SBA_IDLE  = 2'b00,
      SBA_GRANT = 2'b01,
      SBA_BUSY  = 2'b10,
      SBA_EXT   = 2'b11
   } sba_state_e;
endpackage

// *** pkg/sba_arb_if.sv ***
`timescale 1ns/1ps
// Purpose: Carries request and grant between the top and the rotator
// Assumes: Active-high vectors, index 4 is the bridge itself
// Notes:   One modport per side
interface sba_arb_if;
   logic [4:0] req;
   logic [3:0] hi_grp;
   logic       take;
   logic [4:0] win;
   logic       any;
   modport top (output req, output hi_grp, output take, input win, input any);
   modport rot (input req, input hi_grp, input take, output win, output any);
endinterface

// *** hw/sba_rot.sv ***
`timescale 1ns/1ps
// Purpose: Two-level rotating priority pick among five requesters
// Assumes: Bridge (index 4) always sits in the high group
// Notes:   Pointers advance only when the top says a grant was taken
module sba_rot (
   input  wire logic mclk,
   input  wire logic rst,
   sba_arb_if.rot    arb
);
   logic [2:0] hi_last_reg;
   logic [2:0] lo_last_reg;
   logic [4:0] hi_req;
   logic [4:0] lo_req;
   logic [4:0] hi_pick;
   logic [4:0] lo_pick;

   // Split requests by group
   always_comb begin
      hi_req = arb.req & {1'b1, arb.hi_grp};
      lo_req = arb.req & {1'b0, ~arb.hi_grp};
   end

   // Round-robin search starting after the last winner
   function automatic logic [4:0] rr(input logic [4:0] r,
                                     input logic [2:0] last);
      logic [4:0] g;
      logic [2:0] idx;
      g = 5'h00;
      for (int k = 1; k <= 5; k++) begin
         idx = 3'((int'(last) + k) % 5);
         if (g == 5'h00 && r[idx])
            g[idx] = 1'b1;
      end
      return g;
   endfunction

   always_comb begin
      hi_pick = rr(hi_req, hi_last_reg);
      lo_pick = rr(lo_req, lo_last_reg);
      arb.win = (hi_req != 5'h00) ? hi_pick : lo_pick;
      arb.any = (arb.req != 5'h00);
   end

   // last winner drops to the bottom
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         hi_last_reg <= 3'h4;
         lo_last_reg <= 3'h4;
      end else if (arb.take) begin
         for (int i = 0; i < 5; i++) begin
            if (arb.win[i] && hi_req != 5'h00)
               hi_last_reg <= 3'(i);
            else if (arb.win[i])
               lo_last_reg <= 3'(i);
         end
      end
   end
endmodule // sba_rot

// *** hw/sba_clkgen.sv ***
`timescale 1ns/1ps
// Purpose: Five gated secondary clock outputs from one divided reference
// Assumes: Reference is mclk divided to stand in for the primary clock
// Notes:   Each output held at 0 while gated off
module sba_clkgen #(
   parameter int HALF = sba_pkg::CLK_HALF
) (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic [4:0] off,
   output logic [4:0]      clk_o
);
   logic [2:0] cnt_reg;
   logic       ref_reg;
   logic       wrap;

   // Last count of a half period, where the reference flips
   assign wrap = (cnt_reg == 3'(HALF - 1));

   // single reference so all outputs share one frequency
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_reg <= sba_pkg::DIV_W0;
         ref_reg <= 1'b0;
      end else if (cnt_reg == 3'(HALF - 1)) begin
         cnt_reg <= sba_pkg::DIV_W0;
         ref_reg <= ~ref_reg;
      end else begin
         cnt_reg <= cnt_reg + 3'h1;
      end
   end

   // per-output gating, held low when off
   genvar g;
   generate
      for (g = 0; g < sba_pkg::NCLK; g++) begin : g_out
         always_ff @(posedge mclk or posedge rst) begin
            if (rst)
               clk_o[g] <= 1'b0;
            else
               clk_o[g] <= off[g] ? 1'b0 : ~ref_reg ^ wrap;
         end
      end
   endgenerate
endmodule // sba_clkgen

// *** test/sba_master_model.sv ***
`timescale 1ns/1ps
// Purpose: Secondary bus masters and an external arbiter
// Assumes: Lines change just after rising mclk; a served master drops
// Notes:   Each transfer keeps the bus busy for three cycles
module sba_master_model (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic [3:0] want,
   input  wire logic       ext_mode,
   input  wire logic       ext_gnt,
   input  wire logic [3:0] gnt_n,
   output logic [3:0]      req_n,
   output logic            bus_idle
);
   logic [3:0] pend_reg;
   logic [1:0] busy_reg;
   logic [3:0] hit;

   // Line 0 is not a grant while the block asks an outside arbiter
   assign hit = ~gnt_n & pend_reg & {3'h7, ~ext_mode};
   assign req_n = {~pend_reg[3:1], ext_mode ? ~ext_gnt : ~pend_reg[0]};

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pend_reg <= 4'h0;
         busy_reg <= 2'h0;
      end else if (bus_idle && |hit) begin
         pend_reg <= (pend_reg | want) & ~hit;
         busy_reg <= 2'h3;
      end else begin
         pend_reg <= pend_reg | want;
         busy_reg <= busy_reg - {1'b0, |busy_reg};
      end
   end

   assign bus_idle = (busy_reg == 2'h0);
endmodule // sba_master_model

// *** test/tb.sv ***
`timescale 1ns/1ps
// Purpose: Self-checking bench for the secondary arbiter block
// Assumes: Inputs change on rising mclk by non-blocking assignment
// Notes:   Random groups and requests come from a fixed seed
module tb;
   logic       mclk = 0, rst = 1, cfn = 0, pwr = 0, d3 = 0;
   logic       breq = 0, egnt = 0, sb = 0, cb = 0;
   logic [3:0] want = 0, hi = 0, req_n, gnt_n, gnt_oe, w;
   logic [4:0] cdis = 0, sclk, seen;
   logic       idle, bgnt, park, srst_n, sctl_oe, szero, poe_n;
   int         errors = 0, tests_run = 0, seed = 90896, cyc = 0;
   int         who;

   always #2 mclk = ~mclk;

   sba_top dut (.mclk(mclk), .rst(rst), .cfn_strap(cfn), .pwr_strap(pwr),
      .d3hot(d3), .req_n(req_n), .bridge_req(breq), .bus_idle(idle),
      .hi_grp(hi), .clk_dis(cdis), .sec_rst_bit(sb), .chip_rst_bit(cb),
      .gnt_n_o(gnt_n), .gnt_n_oe(gnt_oe), .bridge_gnt(bgnt),
      .bridge_park(park), .sclk_o(sclk), .srst_n(srst_n),
      .sctl_oe(sctl_oe), .sdata_zero(szero), .p_oe_n(poe_n));

   sba_master_model peer (.mclk(mclk), .rst(rst), .want(want),
      .ext_mode(cfn), .ext_gnt(egnt), .gnt_n(gnt_n), .req_n(req_n),
      .bus_idle(idle));

   task check(string what, logic [7:0] seen_v, logic [7:0] exp);
      tests_run++;
      if (seen_v !== exp) begin
         errors++;
         $display("[ERR] %s exp %h seen %h", what, exp, seen_v);
      end
   endtask

   task test_done;
      if (errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task tick(int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // Drain leftovers, pulse requests, wait bounded for a grant
   task serve(logic [3:0] r);
      for (int k = 0; k < 60 && !(req_n === 4'hF && idle === 1'b1 &&
           gnt_n === 4'hF); k++)
         tick(1);
      @(posedge mclk);
      want <= r;
      @(posedge mclk);
      want <= 4'h0;
      who = 7;
      for (int k = 0; k < 20 && who == 7; k++) begin
         tick(1);
         for (int i = 0; i < 4; i++)
            if (gnt_n[i] === 1'b0) who = i;
      end
      tick(8);
   endtask

   // Requester allowed to win: high-group ones if any ask
   function logic pick_ok(logic [3:0] r, logic [3:0] h, int k);
      logic [3:0] pool;
      pool = ((r & h) != 4'h0) ? (r & h) : r;
      return k >= 0 && k < 4 && pool[k[1:0]];
   endfunction

   // Clocks that should run for given gates and sleep straps
   function logic [4:0] exp_clk(logic [4:0] dis, logic p, logic d);
      return (p && d) ? 5'h00 : ~dis;
   endfunction

   // Timeout sized well above the whole sequence
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         test_done;
      end
   end

   always @(negedge mclk)
      if (!rst && !cfn) check("one grant", $countones(~gnt_n) <= 1, 1);

   initial begin
      tick(16);
      check("p_oe_n", poe_n, 1);
      check("gnt_n_oe", gnt_oe, 4'hF);
      check("srst_n", srst_n, 0);
      @(posedge mclk);
      rst <= 0;
      tick(2);
      check("srst_n", srst_n, 1);
      for (int b = 0; b < 2; b++) begin
         @(posedge mclk);
         sb <= (b == 0);
         cb <= (b == 1);
         tick(2);
         check("srst_n", srst_n, 0);
         check("gnt_n_oe", gnt_oe, 4'hF);
         check("sctl_oe", sctl_oe, 1);
         check("sdata_zero", szero, 1);
         check("p_oe_n", poe_n, 0);
         @(posedge mclk);
         sb <= 0;
         cb <= 0;
         tick(2);
         check("srst_n", srst_n, 1);
         check("gnt_n_oe", gnt_oe, 4'h0);
      end
      for (int i = 0; i < 4; i++) begin
         serve(4'h1 << i);
         check("lone grant", who, i);
      end
      hi <= 4'h4;
      serve(4'h6);
      check("high first", who, 2);
      hi <= 4'hB;
      serve(4'h5);
      check("group move", who, 0);
      hi <= 4'hA;
      serve(4'h2);
      check("lone high", who, 1);
      serve(4'hA);
      check("rotated", who, 3);
      repeat (30) begin
         hi <= 4'($random(seed));
         w = 4'($random(seed));
         if (w == 4'h0) w = 4'h8;
         serve(w);
         check("in set", pick_ok(w, hi, who), 1);
      end
      serve(4'h0);
      @(posedge mclk);
      breq <= 1;
      tick(4);
      check("bridge_gnt", bgnt, 1);
      check("no grant", gnt_n, 4'hF);
      @(posedge mclk);
      breq <= 0;
      tick(4);
      check("bridge_gnt", bgnt, 0);
      @(posedge mclk);
      cfn <= 1;
      breq <= 1;
      want <= 4'h2;
      tick(3);
      check("req out", gnt_n[0], 0);
      check("no arb", gnt_n[3:1], 3'h7);
      check("gnt_n_oe", gnt_oe, 4'hE);
      @(posedge mclk);
      want <= 0;
      egnt <= 1;
      tick(3);
      check("bridge_gnt", bgnt, 1);
      check("park busy", park, 0);
      @(posedge mclk);
      breq <= 0;
      tick(3);
      check("req out", gnt_n[0], 1);
      check("park", park, 1);
      @(posedge mclk);
      egnt <= 0;
      cfn <= 0;
      tick(14);
      repeat (10) begin
         @(posedge mclk);
         cdis <= 5'($random(seed));
         pwr <= 1'($random(seed));
         d3 <= 1'($random(seed));
         tick(3);
         seen = 5'h00;
         repeat (20) begin
            tick(1);
            seen = seen | sclk;
         end
         check("clk run", seen, exp_clk(cdis, pwr, d3));
      end
      test_done;
   end
endmodule // tb
